/* File: core/tca_port.v */
`timescale 1ns/1ns
`default_nettype none
`include "tca_regs.vh"
module tca_port
(
    input  wire        sys_clk_i,
    input  wire        rst_b_i,
    input  wire        frame_sync_pin_i,
    input  wire        bit_clock_pin_i,
    input  wire        serial_in_pin_i,
    input  wire        chain_in_pin_i,
    input  wire        port_disable_i,
    input  wire [7:0]  rd_data_i,
    input  wire        audio_ready_i,
    output reg         serial_out_pin_o,
    output reg         serial_out_oe_o,
    output reg         chain_out_pin_o,
    output reg         tdm_cmd_audio_mode_o,
    output reg  [4:0]  dev_id_o,
    output reg         cmd_wr_o,
    output reg  [6:0]  cmd_reg_o,
    output reg  [7:0]  cmd_data_o,
    output reg         rd_req_o,
    output wire        audio_valid_o,
    output wire        audio_right_o,
    output wire [23:0] audio_data_o,
    output reg         audio_overrun_o
);
    // ------------------------------------------------------------
    // pin synchronisers and bit clock edges
    // ------------------------------------------------------------
    reg  [3:0] sync1_r;
    reg  [3:0] sync2_r;
    reg        bck_d_r;
    wire       bit_clock;
    wire       fs;
    wire       sin;
    wire       cin;
    wire       rise;
    wire       fall;

    assign bit_clock  = sync2_r[0];
    assign fs   = sync2_r[1];
    assign sin  = sync2_r[2];
    assign cin  = sync2_r[3];
    assign rise = bit_clock & ~bck_d_r;
    assign fall = ~bit_clock & bck_d_r;

    always @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            bck_d_r <= 1'b0;
        end
        else
        begin
            // two flops ahead of any logic that reads a pin
            sync1_r <= {chain_in_pin_i, serial_in_pin_i,
                        frame_sync_pin_i, bit_clock_pin_i};
            sync2_r <= sync1_r;
            bck_d_r <= bit_clock;
        end
    end

    // ------------------------------------------------------------
    // command decode and field count helpers
    // ------------------------------------------------------------
    // broadcast and none
    function sel_wr;
        input [31:0] w;
        input [4:0]  id;
        begin
            sel_wr = ~w[`TCA_CS_BIT] & ~w[`TCA_RW_BIT] &
                     (w[`TCA_DEV_MSB:`TCA_DEV_LSB] != `TCA_NONE_ID) &
                     ((w[`TCA_DEV_MSB:`TCA_DEV_LSB] == `TCA_BCAST_ID) |
                      (w[`TCA_DEV_MSB:`TCA_DEV_LSB] == id));
        end
    endfunction

    function [5:0] inc6;
        input [5:0] v;
        begin
            inc6 = (v == 6'h3f) ? v : v + 6'h01;
        end
    endfunction

    // ------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------
    reg  [1:0]  width_r;
    reg  [1:0]  short_cnt_r;
    reg         fs_prev_r;
    reg         frame_on_r;
    reg  [4:0]  pos_r;
    reg  [5:0]  field_r;
    reg  [31:0] sh_r;
    reg         id_frame_r;
    reg         ext_frame_r;
    reg         ext_more_r;
    reg         seen_r;
    reg         grant_r;
    reg  [5:0]  grant_field_r;
    reg         rd_sel_r;
    reg  [7:0]  rd_sh_r;
    reg         push_r;
    reg  [24:0] push_d_r;

    wire [31:0] word;
    wire [8:0]  head9;
    wire        seen_now;
    wire        id_now;
    wire        ext_now;
    wire        buf_ready;
    wire        cmd_ok;
    wire [5:0]  ch_last;

    assign word     = {sh_r[30:0], sin};
    assign head9    = {sh_r[7:0], sin};
    assign seen_now = seen_r | cin;
    assign id_now   = (field_r == 6'h00) ? word[`TCA_ID_FLAG_BIT]
                                         : id_frame_r;
    assign ext_now  = (field_r == 6'h00) ?
                      (word[`TCA_EXT_BIT] & ~word[`TCA_ID_FLAG_BIT])
                      : ext_frame_r;
    assign cmd_ok   = (field_r == 6'h00) ? ~head9[8] : ext_more_r;
    assign ch_last  = grant_field_r + 6'h02;

    always @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            width_r              <= 2'h0;
            short_cnt_r          <= 2'h0;
            fs_prev_r            <= 1'b0;
            frame_on_r           <= 1'b0;
            tdm_cmd_audio_mode_o <= 1'b0;
            pos_r                <= 5'h1f;
            field_r              <= 6'h00;
            sh_r                 <= 32'h0;
            id_frame_r           <= 1'b0;
            ext_frame_r          <= 1'b0;
            ext_more_r           <= 1'b0;
            seen_r               <= 1'b0;
            grant_r              <= 1'b0;
            grant_field_r        <= 6'h00;
            dev_id_o             <= `TCA_NONE_ID;
            cmd_wr_o             <= 1'b0;
            cmd_reg_o            <= 7'h00;
            cmd_data_o           <= 8'h00;
            rd_req_o             <= 1'b0;
            rd_sel_r             <= 1'b0;
            push_r               <= 1'b0;
            push_d_r             <= 25'h0;
        end
        else
        begin
            cmd_wr_o <= 1'b0;
            rd_req_o <= 1'b0;
            push_r   <= 1'b0;
            if (rise)
            begin
                fs_prev_r <= fs;
                if (fs && !fs_prev_r)
                begin
                    // frame active only if mode already on
                    width_r     <= 2'h1;
                    frame_on_r  <= tdm_cmd_audio_mode_o;
                    pos_r       <= 5'h1e;
                    field_r     <= 6'h00;
                    sh_r        <= {31'h0, sin};
                    seen_r      <= cin;
                    grant_r     <= 1'b0;
                    id_frame_r  <= 1'b0;
                    ext_frame_r <= 1'b0;
                    ext_more_r  <= 1'b0;
                    rd_sel_r    <= 1'b0;
                end
                else
                begin
                    if (fs && width_r != 2'h3)
                        width_r <= width_r + 2'h1;
                    if (!fs && fs_prev_r)
                    begin
                        if (width_r == `TCA_SHORT_PULSE)
                        begin
                            if (short_cnt_r + 2'h1 >= `TCA_ENTRY_FRAMES)
                                tdm_cmd_audio_mode_o <= 1'b1;
                            if (short_cnt_r != `TCA_ENTRY_FRAMES)
                                short_cnt_r <= short_cnt_r + 2'h1;
                        end
                        else
                        begin
                            short_cnt_r          <= 2'h0;
                            tdm_cmd_audio_mode_o <= 1'b0;
                            frame_on_r           <= 1'b0;
                        end
                    end
                    sh_r   <= word;
                    pos_r  <= pos_r - 5'h01;
                    seen_r <= seen_now;
                    if (frame_on_r && pos_r == `TCA_POS_RW)
                    begin
                        // read target known after rw bit
                        rd_sel_r <= cmd_ok & ~head9[6] & head9[0] &
                                    (dev_id_o != `TCA_NONE_ID) &
                                    (head9[5:1] == dev_id_o);
                    end
                    if (frame_on_r && rd_sel_r &&
                        pos_r == `TCA_POS_REG_DONE)
                    begin
                        rd_req_o  <= 1'b1;
                        cmd_reg_o <= word[6:0];
                    end
                    if (frame_on_r && pos_r == 5'h00)
                    begin
                        field_r <= inc6(field_r);
                        seen_r  <= 1'b0;
                        if (field_r == 6'h00)
                        begin
                            id_frame_r  <= word[`TCA_ID_FLAG_BIT];
                            ext_frame_r <= ext_now;
                            ext_more_r  <= ext_now;
                        end
                        else if (ext_more_r)
                            ext_more_r <= word[`TCA_EXT_BIT];
                        // act on command and extended fields
                        // field 0 holds a command unless its id flag is set; later fields
                        // only while the field before had its extension bit set
                        if ((field_r == 6'h00 || ext_more_r) &&
                            !(field_r == 6'h00 && word[`TCA_ID_FLAG_BIT]) &&
                            sel_wr(word, dev_id_o))
                        begin
                            cmd_wr_o   <= 1'b1;
                            cmd_reg_o  <= word[`TCA_REG_MSB:`TCA_REG_LSB];
                            cmd_data_o <= word[`TCA_DATA_MSB:`TCA_DATA_LSB];
                        end
                        // chain input seen during this field
                        if (!ext_now && seen_now && !grant_r)
                        begin
                            grant_r       <= 1'b1;
                            grant_field_r <= field_r;
                            // limit to 30, head gets 1
                            if (id_now && inc6(field_r) <= `TCA_MAX_ID)
                                dev_id_o <= field_r[4:0] + 5'h01;
                        end
                        // our channels only while port enabled
                        if (!ext_now && !id_now && grant_r &&
                            !port_disable_i &&
                            (field_r == grant_field_r + 6'h01 ||
                             field_r == ch_last))
                        begin
                            push_r   <= 1'b1;
                            push_d_r <= {field_r == ch_last,
                                         word[`TCA_AUD_MSB:`TCA_AUD_LSB]};
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read data output, chain output and overrun flag
    // ------------------------------------------------------------
    always @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            serial_out_pin_o <= 1'b0;
            serial_out_oe_o  <= 1'b0;
            rd_sh_r          <= 8'h00;
            chain_out_pin_o  <= 1'b0;
            audio_overrun_o  <= 1'b0;
        end
        else
        begin
            // a word meeting a full buffer is dropped and flagged
            audio_overrun_o <= push_r & ~buf_ready;
            if (fall)
            begin
                if (!rd_sel_r || !frame_on_r ||
                    pos_r == `TCA_POS_DATA_END)
                begin
                    serial_out_oe_o  <= 1'b0;
                    serial_out_pin_o <= 1'b0;
                end
                else if (pos_r == `TCA_POS_EARLY_OE)
                begin
                    serial_out_oe_o  <= 1'b1;
                    serial_out_pin_o <= 1'b0;
                end
                else if (pos_r == `TCA_POS_DATA_MSB)
                begin
                    rd_sh_r          <= rd_data_i;
                    serial_out_pin_o <= rd_data_i[7];
                end
                // pos_r 14..8 picks data bits 6..0
                else if (pos_r > `TCA_POS_DATA_END &&
                         pos_r < `TCA_POS_DATA_MSB)
                    serial_out_pin_o <= rd_sh_r[pos_r[2:0]];
            end
            if (!frame_on_r || ext_frame_r)
                chain_out_pin_o <= 1'b0;
            else if (id_frame_r)
                chain_out_pin_o <= grant_r && field_r > grant_field_r;
            // skipped device hands the chain input straight on
            else if (port_disable_i)
                chain_out_pin_o <= cin;
            else
                chain_out_pin_o <= grant_r && field_r == ch_last;
        end
    end

    // ------------------------------------------------------------
    // audio word buffer
    // ------------------------------------------------------------
    tca_buf2 u_buf
    (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (push_r),
        .in_data_i   (push_d_r),
        .in_ready_o  (buf_ready),
        .out_valid_o (audio_valid_o),
        .out_data_o  ({audio_right_o, audio_data_o}),
        .out_ready_i (audio_ready_i)
    );
endmodule
`default_nettype wire

/* File: core/tca_regs.vh */
`ifndef TCA_REGS_VH
`define TCA_REGS_VH

`define TCA_ID_FLAG_BIT   31
`define TCA_EXT_BIT       30
`define TCA_CS_BIT        29
`define TCA_DEV_MSB       28
`define TCA_DEV_LSB       24
`define TCA_RW_BIT        23
`define TCA_REG_MSB       22
`define TCA_REG_LSB       16
`define TCA_DATA_MSB      15
`define TCA_DATA_LSB      8
`define TCA_AUD_MSB       31
`define TCA_AUD_LSB       8
`define TCA_SHORT_PULSE   2'h2
`define TCA_ENTRY_FRAMES  2'h2
`define TCA_MAX_ID        6'h1e
`define TCA_BCAST_ID      5'h1f
`define TCA_NONE_ID       5'h00
`define TCA_POS_RW        5'h17
`define TCA_POS_REG_DONE  5'h10
`define TCA_POS_EARLY_OE  5'h10
`define TCA_POS_DATA_MSB  5'h0f
`define TCA_POS_DATA_END  5'h07

`endif

/* File: core/tca_buf2.v */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// two-entry buffer: output stage plus one spare stage
// ----------------------------------------------------------------
module tca_buf2
(
    input  wire        sys_clk_i,
    input  wire        rst_b_i,
    input  wire        in_valid_i,
    input  wire [24:0] in_data_i,
    output wire        in_ready_o,
    output reg         out_valid_o,
    output reg  [24:0] out_data_o,
    input  wire        out_ready_i
);
    reg        spare_v_r;
    reg [24:0] spare_d_r;
    wire       take;

    assign in_ready_o = ~spare_v_r;
    assign take       = in_valid_i & ~spare_v_r;

    always @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            out_valid_o <= 1'b0;
            out_data_o  <= 25'h0;
            spare_v_r   <= 1'b0;
            spare_d_r   <= 25'h0;
        end
        else if (!out_valid_o || out_ready_i)
        begin
            if (spare_v_r)
            begin
                out_valid_o <= 1'b1;
                out_data_o  <= spare_d_r;
                spare_v_r   <= take;
                if (take)
                    spare_d_r <= in_data_i;
            end
            else
            begin
                out_valid_o <= take;
                if (take)
                    out_data_o <= in_data_i;
            end
        end
        else if (take)
        begin
            spare_v_r <= 1'b1;
            spare_d_r <= in_data_i;
        end
    end
endmodule
`default_nettype wire

/* File: test/tca_port_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module tca_port_checker
(
    input wire logic        sys_clk_i,
    input wire logic        rst_b_i,
    input wire logic        audio_ready_i,
    input wire logic        serial_out_oe_o,
    input wire logic        tdm_cmd_audio_mode_o,
    input wire logic [4:0]  dev_id_o,
    input wire logic        cmd_wr_o,
    input wire logic        rd_req_o,
    input wire logic        audio_valid_o,
    input wire logic        audio_right_o,
    input wire logic [23:0] audio_data_o,
    input wire logic        audio_overrun_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // --------
    // port rules
    // --------
    reset_zero_a:
    assert property ($rose(rst_b_i) |-> !tdm_cmd_audio_mode_o
        && !serial_out_oe_o && dev_id_o == 5'h00 && !audio_valid_o)
    else $error("outputs not cleared by reset");
    wr_in_mode_a:
    assert property (cmd_wr_o |-> tdm_cmd_audio_mode_o)
    else $error("write outside mode");
    rd_own_id_a:
    assert property (rd_req_o |-> tdm_cmd_audio_mode_o && dev_id_o != 5'h00)
    else $error("read without identifier");
    wr_pulse_a:
    assert property (cmd_wr_o |=> !cmd_wr_o)
    else $error("write pulse too long");
    rd_oe_early_a:
    assert property (rd_req_o |-> serial_out_oe_o [*8])
    else $error("output not enabled ahead of data");
    oe_leads_rd_a:
    assert property ($rose(serial_out_oe_o) |-> ##[1:16] rd_req_o)
    else $error("output enabled without read");
    oe_mode_a:
    assert property (serial_out_oe_o |-> tdm_cmd_audio_mode_o)
    else $error("output enabled outside mode");
    audio_hold_a:
    assert property (audio_valid_o && !audio_ready_i |=> audio_valid_o
        && $stable(audio_data_o) && $stable(audio_right_o))
    else $error("audio word dropped while stalled");
    overrun_full_a:
    assert property (audio_overrun_o |-> audio_valid_o)
    else $error("overrun with empty buffer");
    id_range_a:
    assert property (dev_id_o != 5'h1f)
    else $error("identifier above range");
    id_mode_a:
    assert property ($changed(dev_id_o) |-> tdm_cmd_audio_mode_o)
    else $error("identifier changed outside mode");
endmodule
`default_nettype wire

/* File: test/tca_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module tca_host_model
(
    input  wire logic sys_clk_i,
    input  wire logic serial_out_pin_i,
    input  wire logic serial_out_oe_i,
    input  wire logic chain_out_pin_i,
    output var  logic frame_sync_o,
    output var  logic bit_clock_o,
    output var  logic serial_in_o,
    output var  logic chain_in_o
);
    logic [31:0] fld [0:7];
    int          nfld = 1;
    int          pw = 2;
    int          chain_fld = 9;
    logic [7:0]  rd_q;
    logic        oe_early;
    logic        oe_late;
    logic [7:0]  cho;
    initial
    begin
        frame_sync_o = 1'b0;
        bit_clock_o = 1'b0;
        serial_in_o = 1'b0;
        chain_in_o = 1'b0;
        foreach (fld[j]) fld[j] = 32'h0;
    end
    // --------
    // one frame, bit clock still outside it
    // --------
    task automatic frame();
        int k;
        int b;
        for (k = 0; k < nfld; k++)
        begin
            for (b = 31; b >= 0; b--)
            begin
                serial_in_o = fld[k][b];
                // sync pulse pw bit clocks long, one per frame
                frame_sync_o = (k == 0) && (b > 31 - pw);
                // previous device output, no portless ahead
                chain_in_o = (chain_fld < 0) || (chain_fld == k);
                bit_clock_o = 1'b0;
                repeat (4) @(negedge sys_clk_i);
                bit_clock_o = 1'b1;
                repeat (3) @(negedge sys_clk_i);
                if (k == 0 && b <= 15 && b >= 8)
                    rd_q = {rd_q[6:0], serial_out_pin_i};
                if (k == 0 && b == 16)
                    oe_early = serial_out_oe_i;
                if (k == 0 && b == 7)
                    oe_late = serial_out_oe_i;
                if (b == 16)
                    cho[k] = chain_out_pin_i;
                @(negedge sys_clk_i);
            end
        end
        bit_clock_o = 1'b0;
        serial_in_o = ~serial_in_o;
        frame_sync_o = 1'b0;
        chain_in_o = (chain_fld < 0);
        repeat (8) @(negedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

/* File: test/tca_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tca_port_tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        fs, bclk, sdi, ci, so, soe, co, mode;
    logic        pdis = 1'b0;
    logic        ardy = 1'b1;
    logic [7:0]  rdd = 8'ha5;
    logic [4:0]  dev_id;
    logic        cwr, rdq, av, ar, aovr;
    logic [6:0]  creg;
    logic [7:0]  cdat;
    logic [23:0] ad;
    logic [33:0] rows [0:5];
    logic [24:0] aq [$];
    logic [14:0] last_wr;
    logic [6:0]  last_rd;
    int          fails = 0;
    int          samples_checked = 0;
    int          wr_cnt = 0;
    int          rd_cnt = 0;
    int          ovr_cnt = 0;
    int          i, w0, r0;
    always #25 clk = ~clk;
    tca_port i_tca_port (.sys_clk_i(clk), .rst_b_i(rst_b),
        .frame_sync_pin_i(fs), .bit_clock_pin_i(bclk),
        .serial_in_pin_i(sdi), .chain_in_pin_i(ci), .port_disable_i(pdis),
        .rd_data_i(rdd), .audio_ready_i(ardy), .serial_out_pin_o(so),
        .serial_out_oe_o(soe), .chain_out_pin_o(co),
        .tdm_cmd_audio_mode_o(mode), .dev_id_o(dev_id), .cmd_wr_o(cwr),
        .cmd_reg_o(creg), .cmd_data_o(cdat), .rd_req_o(rdq),
        .audio_valid_o(av), .audio_right_o(ar), .audio_data_o(ad),
        .audio_overrun_o(aovr));
    tca_host_model i_tca_host_model (.sys_clk_i(clk),
        .serial_out_pin_i(so), .serial_out_oe_i(soe),
        .chain_out_pin_i(co), .frame_sync_o(fs), .bit_clock_o(bclk),
        .serial_in_o(sdi), .chain_in_o(ci));
    always @(posedge clk)
    begin
        if (cwr)
            wr_cnt <= wr_cnt + 1;
        if (cwr)
            last_wr <= {creg, cdat};
        if (rdq)
            rd_cnt <= rd_cnt + 1;
        if (rdq)
            last_rd <= creg;
        if (aovr)
            ovr_cnt <= ovr_cnt + 1;
        if (av && ardy)
            aq.push_back({ar, ad});
    end
    // --------
    // helpers
    // --------
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [31:0] mk(input logic cs, input logic [4:0] dv,
        input logic rw, input logic [6:0] rg, input logic [7:0] d);
        return {2'b00, cs, dv, rw, rg, d, 8'h00};
    endfunction
    task automatic send(input logic [31:0] a, input logic [31:0] b,
        input logic [31:0] c, input int n, input int cf);
        i_tca_host_model.fld[0] = a;
        i_tca_host_model.fld[1] = b;
        i_tca_host_model.fld[2] = c;
        i_tca_host_model.nfld = n;
        i_tca_host_model.chain_fld = cf;
        i_tca_host_model.frame();
    endtask
    initial
    begin
        #3000000;
        fails++;
        close_out();
    end
    // --------
    // tests
    // --------
    initial
    begin
        rows[0] = {2'b10, mk(1'b0, 5'h03, 1'b0, 7'h12, 8'h5a) | 32'hff};
        rows[1] = {2'b10, mk(1'b0, 5'h1f, 1'b0, 7'h13, 8'h3c)};
        rows[2] = {2'b00, mk(1'b0, 5'h00, 1'b0, 7'h14, 8'h01)};
        rows[3] = {2'b00, mk(1'b0, 5'h04, 1'b0, 7'h14, 8'h02)};
        rows[4] = {2'b00, mk(1'b1, 5'h03, 1'b0, 7'h14, 8'h03)};
        rows[5] = {2'b00, mk(1'b0, 5'h1f, 1'b1, 7'h14, 8'h04)};
        repeat (6) @(negedge clk);
        check({mode, soe, dev_id, av}, 32'h0);
        rst_b = 1'b1;
        send(mk(1'b0, 5'h1f, 1'b0, 7'h01, 8'h11), 32'h0, 32'h0, 1, 9);
        check(mode, 1'b0);
        send(mk(1'b0, 5'h1f, 1'b0, 7'h01, 8'h11), 32'h0, 32'h0, 1, 9);
        check(mode, 1'b1);
        check(wr_cnt, 0);
        send(32'h8000_0000, 32'h0, 32'h0, 3, -1);
        check(dev_id, 5'h01);
        send(32'hff7f_ff00, 32'h0, 32'h0, 5, 2);
        check(dev_id, 5'h03);
        check(wr_cnt, 0);
        check(i_tca_host_model.cho[4:2], 3'b110);
        for (i = 0; i < 6; i++)
        begin
            w0 = wr_cnt;
            r0 = rd_cnt;
            send(rows[i][31:0], 32'h0, 32'h0, 1, 9);
            check(wr_cnt - w0, rows[i][33]);
            check(rd_cnt - r0, rows[i][32]);
            if (rows[i][33])
                check(last_wr, rows[i][22:8]);
        end
        send(mk(1'b0, 5'h03, 1'b1, 7'h15, 8'h00), 32'h0, 32'h0, 1, 9);
        check(last_rd, 7'h15);
        check(i_tca_host_model.rd_q, 8'ha5);
        check({i_tca_host_model.oe_early, i_tca_host_model.oe_late}, 2'b10);
        w0 = wr_cnt;
        send(mk(1'b0, 5'h03, 1'b0, 7'h01, 8'h21) | 32'h4000_0000,
            mk(1'b0, 5'h03, 1'b0, 7'h02, 8'h22), 32'h1234_5600, 3, 0);
        check(wr_cnt - w0, 2);
        check(last_wr, {7'h02, 8'h22});
        check(aq.size(), 0);
        send(32'h0, 32'h1234_56ff, 32'habcd_ef00, 3, 0);
        repeat (4) @(negedge clk);
        check(aq.size(), 2);
        check(aq[0], {1'b0, 24'h123456});
        check(aq[1], {1'b1, 24'habcdef});
        check(i_tca_host_model.cho[2:1], 2'b10);
        aq.delete();
        pdis = 1'b1;
        send(32'h0, 32'h1234_5600, 32'habcd_ef00, 3, 0);
        check(aq.size(), 0);
        check(i_tca_host_model.cho[1:0], 2'b01);
        pdis = 1'b0;
        ardy = 1'b0;
        send(32'h0, 32'h1234_5600, 32'habcd_ef00, 3, 0);
        check(ovr_cnt, 0);
        send(32'h0, 32'h5555_5500, 32'h6666_6600, 3, 0);
        check(ovr_cnt, 2);
        ardy = 1'b1;
        repeat (8) @(negedge clk);
        check(aq.size(), 2);
        check(aq[1], {1'b1, 24'habcdef});
        i_tca_host_model.pw = 3;
        send(mk(1'b0, 5'h03, 1'b0, 7'h01, 8'h01), 32'h0, 32'h0, 1, 9);
        check(mode, 1'b0);
        i_tca_host_model.pw = 2;
        repeat (2)
            send(mk(1'b0, 5'h03, 1'b0, 7'h01, 8'h01), 32'h0, 32'h0, 1, 9);
        check(mode, 1'b1);
        i_tca_host_model.pw = 16;
        send(mk(1'b0, 5'h03, 1'b0, 7'h01, 8'h01), 32'h0, 32'h0, 1, 9);
        check(mode, 1'b0);
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check({mode, soe, dev_id, av}, 32'h0);
        close_out();
    end
endmodule
bind tca_port tca_port_checker i_tca_port_checker (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .audio_ready_i(audio_ready_i),
    .serial_out_oe_o(serial_out_oe_o),
    .tdm_cmd_audio_mode_o(tdm_cmd_audio_mode_o), .dev_id_o(dev_id_o),
    .cmd_wr_o(cmd_wr_o), .rd_req_o(rd_req_o), .audio_valid_o(audio_valid_o),
    .audio_right_o(audio_right_o), .audio_data_o(audio_data_o),
    .audio_overrun_o(audio_overrun_o));
`default_nettype wire
